// *** led_dimming_channel_control.sv ***
// six-channel LED dimming control: straps, PWM, phase shift, brightness path
`timescale 1ns/100ps
`include "ldc_cfg.svh"
// How it works
// R1: sink level is code times brightness scale
// R2: every current code resets to 0xFFF
// R3: strap sampled once, sets grouping and phases
// R4: string arrangement never changes until next reset
// R5: eight arrangements of single, paired, triple groups or one group of all six
// R6: groups evenly spread over one PWM period
// R7: board grounds sinks left unused
// R8: PWM period from 20 MHz tick, eight settings
// R9: one global brightness for all strings
// R10: source select defaults to PWM input
// R11: sloper on by default, sloper and dither writable
// R12: mode strap gives dimming mode and address
// R13: steps per period equal oscillator over frequency
// R14: phase-shift mode: constant delay between groups
// R15: direct mode follows the PWM input pin
// R16: ganged channels switch together, period over groups
module led_dimming_channel_control import ldc_pkg::*; (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // straps
  input wire logic [2:0] string_config_strap,
  input wire logic [2:0] modeStrap,
  input wire logic [2:0] dim_frequency_strap,
  // brightness input pin
  input wire logic pwmIn,
  // i2c
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // sink outputs
  output logic [5:0] sinkEnable,
  output logic [71:0] sinkLevel
);
  // ********************************************************
  // straps
  // ********************************************************
  logic strapsTaken;
  logic [2:0] cfgSel;
  logic [2:0] modeSel;
  logic [2:0] fSel;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strapsTaken <= 1'h0;
      cfgSel <= 3'h0;
      modeSel <= 3'h0;
      fSel <= 3'h0;
    end
    else if (ce && !strapsTaken)
    begin
      // taken once after reset; later strap moves are ignored
      strapsTaken <= 1'h1; // R4
      cfgSel <= string_config_strap; // R3
      modeSel <= modeStrap; // R12
      fSel <= dim_frequency_strap; // R8
    end
  end

  wire ldc_dim_mode_t dimMode = ldc_dim_mode_t'(modeSel[1:0]); // R12
  wire [6:0] devAddr = modeSel[2] ? `LDC_ADDR_HIGH : `LDC_ADDR_LOW; // R12

  function automatic logic [2:0] groupOf(input logic [2:0] cfg, input logic [2:0] ch);
    case (cfg)
      3'h5: groupOf = ch >> 1;
      3'h6: groupOf = (ch > 3'h2) ? 3'h1 : 3'h0;
      3'h7: groupOf = 3'h0;
      default: groupOf = ch;
    endcase
  endfunction

  function automatic logic [2:0] groupCount(input logic [2:0] cfg);
    case (cfg)
      3'h0: groupCount = 3'h6;
      3'h1: groupCount = 3'h5;
      3'h2: groupCount = 3'h4;
      3'h3, 3'h5: groupCount = 3'h3;
      3'h4, 3'h6: groupCount = 3'h2;
      default: groupCount = 3'h1;
    endcase
  endfunction

  // ********************************************************
  // register file
  // ********************************************************
  ldc_reg_if regBus();
  logic srcSel;
  logic [15:0] dispBrt;
  logic [2:0] slopeSel;
  logic [3:0] ditherSel;
  logic [11:0] code [6];
  logic [15:0] curBrt;

  ldc_i2c_slave uI2c (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .devAddr(devAddr),
    .regs(regBus.slave)
  );
  assign sdaOut = 1'h0;

  wire wrHit = ce & regBus.wrStb;
  wire [7:0] codeOff = regBus.ptr - `LDC_REG_CODE_BASE;
  wire [7:0] codeRdOff = regBus.ptr - `LDC_REG_CODE_BASE;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      srcSel <= `LDC_RST_SRC; // R10
      dispBrt <= `LDC_RST_DBRT;
      slopeSel <= `LDC_RST_SLOPE; // R11
      ditherSel <= `LDC_RST_DITHER;
    end
    else if (wrHit)
    begin
      if (regBus.ptr == `LDC_REG_SRC)
        srcSel <= regBus.wdata[0]; // R10
      if (regBus.ptr == `LDC_REG_DBRT_L)
        dispBrt[7:0] <= regBus.wdata;
      if (regBus.ptr == `LDC_REG_DBRT_H)
        dispBrt[15:8] <= regBus.wdata;
      if (regBus.ptr == `LDC_REG_SLOPE)
        slopeSel <= regBus.wdata[`LDC_SLOPE_MSB:0]; // R11
      if (regBus.ptr == `LDC_REG_DITHER)
        ditherSel <= regBus.wdata[`LDC_DITHER_MSB:0]; // R11
    end
  end

  always_comb
  begin
    regBus.rdata = 8'h00;
    case (regBus.ptr)
      `LDC_REG_SRC: regBus.rdata = {7'h00, srcSel};
      `LDC_REG_DBRT_L: regBus.rdata = dispBrt[7:0];
      `LDC_REG_DBRT_H: regBus.rdata = dispBrt[15:8];
      `LDC_REG_SLOPE: regBus.rdata = {5'h00, slopeSel};
      `LDC_REG_DITHER: regBus.rdata = {4'h0, ditherSel};
      `LDC_REG_STATUS: regBus.rdata = {strapsTaken, 1'h0, modeSel, cfgSel};
      default:
        if (codeRdOff < 8'd12)
          regBus.rdata = codeRdOff[0] ? {4'h0, code[codeRdOff[3:1]][11:8]}
                                      : code[codeRdOff[3:1]][7:0];
    endcase
  end

  // ********************************************************
  // oscillator tick and PWM period
  // ********************************************************
  logic [2:0] oscAcc;
  logic [16:0] pwmCnt;
  logic [3:0] frameCnt;
  wire [2:0] oscSum = oscAcc + 3'(`LDC_OSC_INC);
  wire oscTick = oscSum >= 3'(`LDC_OSC_MOD); // R8
  wire [2:0] next_oscAcc = oscTick ? oscSum - 3'(`LDC_OSC_MOD) : oscSum;
  // one count per oscillator tick, so steps = 20 MHz / frequency
  wire [16:0] periodMask = 17'h1FFFF >> fSel; // R13
  wire periodEnd = oscTick & (pwmCnt == periodMask);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oscAcc <= 3'h0;
      pwmCnt <= 17'h00000;
      frameCnt <= 4'h0;
    end
    else if (ce)
    begin
      oscAcc <= next_oscAcc;
      if (oscTick)
        pwmCnt <= periodEnd ? 17'h00000 : pwmCnt + 17'h00001; // R8
      if (periodEnd)
        frameCnt <= frameCnt + 4'h1;
    end
  end

  // ********************************************************
  // brightness path: input duty, source select, sloper
  // ********************************************************
  logic [15:0] winCnt;
  logic [16:0] highCnt;
  logic [15:0] pwmBrt;
  logic [9:0] slopeDiv;
  wire [15:0] measBrt = highCnt[16] ? 16'hFFFF : highCnt[15:0];
  wire [15:0] measDiff = (measBrt > pwmBrt) ? measBrt - pwmBrt : pwmBrt - measBrt;
  // small duty wobble from slow pin edges must not move the LEDs
  wire measMove = measDiff > 16'(`LDC_HYST_TICKS);
  wire [15:0] targetBrt = srcSel ? dispBrt : pwmBrt; // R9
  wire [9:0] slopeMask = 10'((11'h004 << slopeSel) - 11'h001);
  wire slopeTick = oscTick & ((slopeDiv & slopeMask) == 10'h000);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      winCnt <= 16'h0000;
      highCnt <= 17'h00000;
      pwmBrt <= 16'h0000;
      slopeDiv <= 10'h000;
      curBrt <= 16'h0000;
    end
    else if (ce)
    begin
      if (oscTick)
      begin
        winCnt <= winCnt + 16'h0001;
        slopeDiv <= slopeDiv + 10'h001;
        highCnt <= (winCnt == 16'hFFFF) ? 17'h00000 : highCnt + {16'h0000, pwmIn};
        if (winCnt == 16'hFFFF && measMove)
          pwmBrt <= measBrt;
      end
      if (slopeSel == 3'h0)
        curBrt <= targetBrt; // R11
      else if (slopeTick && curBrt != targetBrt)
        curBrt <= (curBrt < targetBrt) ? curBrt + 16'h0001 : curBrt - 16'h0001; // R11
    end
  end

  // ********************************************************
  // duty, dither and dimming mode
  // ********************************************************
  wire hybLow = (dimMode == LDC_HYBRID) && (curBrt < `LDC_HYB_KNEE);
  wire [15:0] dutyBrt = hybLow ? {curBrt[12:0], 3'h0} : curBrt;
  wire pwmFull = (dimMode == LDC_CURRENT) || ((dimMode == LDC_HYBRID) && !hybLow);
  wire [15:0] levelScale = (dimMode == LDC_CURRENT) ? curBrt
                         : (dimMode == LDC_HYBRID) ? (hybLow ? `LDC_HYB_KNEE : curBrt)
                         : 16'hFFFF;
  wire [20:0] dutyExt = {dutyBrt, dutyBrt[15], 4'h0} >> fSel;
  wire [2:0] ditherBits = (ditherSel > 4'h4) ? 3'h4 : ditherSel[2:0];
  wire [3:0] ditherFrac = dutyExt[3:0] >> (3'h4 - ditherBits);
  wire [3:0] ditherPos = frameCnt & 4'((5'h01 << ditherBits) - 5'h01);
  wire [17:0] dutyEff = {1'h0, dutyExt[20:4]} + {17'h00000, ditherPos < ditherFrac};
  wire [2:0] numGroups = groupCount(cfgSel);
  wire [16:0] recip = 17'(`LDC_PER_MAX / {29'h0, numGroups}); // R16

  // ********************************************************
  // per-channel phase and outputs
  // ********************************************************
  logic [5:0] next_sinkEnable;
  logic [71:0] next_sinkLevel;
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++)
    begin : gCh
      wire [2:0] grp = groupOf(cfgSel, 3'(ch)); // R5 R16
      wire active = (cfgSel > 3'h4) || (3'(ch) < numGroups); // R5
      wire [19:0] offFull = 20'(grp) * {3'h0, recip}; // R6
      wire [16:0] offset = 17'(offFull >> fSel) & periodMask; // R6 R16
      wire [16:0] phase = (pwmCnt - offset) & periodMask; // R14
      wire [27:0] prod = code[ch] * levelScale; // R1
      // full scale drops one LSB in the shift; give it back, but keep code zero dark
      wire roundUp = &levelScale & (|code[ch]); // R1
      wire on = (dimMode == LDC_DIRECT) ? pwmIn // R15
              : (pwmFull | ({1'h0, phase} < dutyEff)); // R14
      assign next_sinkEnable[ch] = active & on;
      assign next_sinkLevel[ch * 12 +: 12] = active ? prod[27:16] + {11'h000, roundUp} // R1
                                                    : 12'h000; // R5

      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          code[ch] <= `LDC_RST_CODE; // R2
        else if (wrHit && codeOff[7:1] == 7'(ch) && codeOff < 8'd12)
        begin
          if (codeOff[0])
            code[ch][11:8] <= regBus.wdata[`LDC_CODE_HI_MSB:0];
          else
            code[ch][7:0] <= regBus.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sinkEnable <= 6'h00;
      sinkLevel <= 72'h0;
    end
    else if (ce)
    begin
      sinkEnable <= strapsTaken ? next_sinkEnable : 6'h00; // R9
      sinkLevel <= next_sinkLevel; // R1
    end
  end
endmodule

// *** ldc_cfg.svh ***
// constants of the LED dimming channel control block
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
// timing
`define LDC_SYS_HZ 50000000
`define LDC_OSC_HZ 20000000
`define LDC_OSC_INC (`LDC_OSC_HZ / 10000000)
`define LDC_OSC_MOD (`LDC_SYS_HZ / 10000000)
`define LDC_HYST_NS 6400
`define LDC_HYST_TICKS ((`LDC_HYST_NS * (`LDC_OSC_HZ / 1000000)) / 1000)
`define LDC_PER_MAX 131072
// i2c slave addresses picked by the mode strap
`define LDC_ADDR_LOW 7'h2B
`define LDC_ADDR_HIGH 7'h2A
// register offsets
`define LDC_REG_SRC 8'h00
`define LDC_REG_DBRT_L 8'h01
`define LDC_REG_DBRT_H 8'h02
`define LDC_REG_SLOPE 8'h03
`define LDC_REG_DITHER 8'h04
`define LDC_REG_STATUS 8'h05
`define LDC_REG_CODE_BASE 8'h10
// field positions
`define LDC_CODE_HI_MSB 3
`define LDC_SLOPE_MSB 2
`define LDC_DITHER_MSB 3
// reset values, full code and hybrid knee
`define LDC_RST_SRC 1'h0
`define LDC_RST_DBRT 16'hFFFF
`define LDC_RST_SLOPE 3'h1
`define LDC_RST_DITHER 4'h0
`define LDC_RST_CODE 12'hFFF
`define LDC_CODE_FULL 12'hFFF
`define LDC_HYB_KNEE 16'h2000
`endif

// *** ldc_pkg.sv ***
// types of the LED dimming channel control block
package ldc_pkg;
  typedef enum logic [1:0] {
    LDC_PSPWM = 2'h0,
    LDC_HYBRID = 2'h1,
    LDC_CURRENT = 2'h2,
    LDC_DIRECT = 2'h3
  } ldc_dim_mode_t;
  typedef enum logic [3:0] {
    LDC_I2C_IDLE = 4'h0,
    LDC_I2C_ADDR = 4'h1,
    LDC_I2C_ACKA = 4'h2,
    LDC_I2C_REG = 4'h3,
    LDC_I2C_ACKR = 4'h4,
    LDC_I2C_WDAT = 4'h5,
    LDC_I2C_ACKW = 4'h6,
    LDC_I2C_RDAT = 4'h7,
    LDC_I2C_RACK = 4'h8
  } ldc_i2c_state_t;
endpackage

// *** ldc_reg_if.sv ***
// register access carrier between the i2c slave and the register file
`timescale 1ns/100ps
interface ldc_reg_if;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic wrStb;
  logic [7:0] rdata;
  modport slave (output ptr, output wdata, output wrStb, input rdata);
  modport regs (input ptr, input wdata, input wrStb, output rdata);
endinterface

// *** ldc_i2c_slave.sv ***
// i2c slave that turns bus transfers into register reads and writes
`timescale 1ns/100ps
module ldc_i2c_slave import ldc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // i2c pins, sda is open drain and only ever pulled low
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOe,
  // strapped address
  input wire logic [6:0] devAddr,
  // register side
  ldc_reg_if.slave regs
);
  ldc_i2c_state_t state;
  logic sclPrev;
  logic sdaPrev;
  logic [7:0] shift;
  logic [3:0] bitCnt;
  logic isRead;
  logic ackOk;

  wire sclRise = sclIn & ~sclPrev;
  wire sclFall = ~sclIn & sclPrev;
  wire startCond = sclIn & sclPrev & sdaPrev & ~sdaIn;
  wire stopCond = sclIn & sclPrev & ~sdaPrev & sdaIn;
  wire inByte = (state == LDC_I2C_ADDR) | (state == LDC_I2C_REG) | (state == LDC_I2C_WDAT);
  wire byteDone = bitCnt == 4'h8;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= LDC_I2C_IDLE;
      sclPrev <= 1'h1;
      sdaPrev <= 1'h1;
      shift <= 8'h00;
      bitCnt <= 4'h0;
      isRead <= 1'h0;
      ackOk <= 1'h0;
      sdaOe <= 1'h0;
      regs.ptr <= 8'h00;
      regs.wdata <= 8'h00;
      regs.wrStb <= 1'h0;
    end
    else if (ce)
    begin
      sclPrev <= sclIn;
      sdaPrev <= sdaIn;
      regs.wrStb <= 1'h0;
      if (startCond)
      begin
        state <= LDC_I2C_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'h0;
      end
      else if (stopCond)
      begin
        state <= LDC_I2C_IDLE;
        sdaOe <= 1'h0;
      end
      else if (sclRise)
      begin
        if (inByte)
        begin
          shift <= {shift[6:0], sdaIn};
          bitCnt <= bitCnt + 4'h1;
        end
        if (state == LDC_I2C_RACK)
          ackOk <= ~sdaIn;
      end
      else if (sclFall)
      begin
        case (state)
          LDC_I2C_ADDR:
            if (byteDone)
            begin
              sdaOe <= shift[7:1] == devAddr;
              isRead <= shift[0];
              state <= (shift[7:1] == devAddr) ? LDC_I2C_ACKA : LDC_I2C_IDLE;
            end
          LDC_I2C_REG:
            if (byteDone)
            begin
              regs.ptr <= shift;
              sdaOe <= 1'h1;
              state <= LDC_I2C_ACKR;
            end
          LDC_I2C_WDAT:
            if (byteDone)
            begin
              regs.wdata <= shift;
              regs.wrStb <= 1'h1;
              sdaOe <= 1'h1;
              state <= LDC_I2C_ACKW;
            end
          LDC_I2C_ACKA, LDC_I2C_RACK:
            if ((state == LDC_I2C_ACKA && isRead) || (state == LDC_I2C_RACK && ackOk))
            begin
              shift <= regs.rdata;
              sdaOe <= ~regs.rdata[7];
              bitCnt <= 4'h0;
              state <= LDC_I2C_RDAT;
            end
            else
            begin
              sdaOe <= 1'h0;
              bitCnt <= 4'h0;
              state <= (state == LDC_I2C_ACKA) ? LDC_I2C_REG : LDC_I2C_IDLE;
            end
          LDC_I2C_ACKR, LDC_I2C_ACKW:
          begin
            // pointer steps after each written byte for burst writes
            if (state == LDC_I2C_ACKW)
              regs.ptr <= regs.ptr + 8'h01;
            sdaOe <= 1'h0;
            bitCnt <= 4'h0;
            state <= LDC_I2C_WDAT;
          end
          LDC_I2C_RDAT:
            if (bitCnt == 4'h7)
            begin
              sdaOe <= 1'h0;
              regs.ptr <= regs.ptr + 8'h01;
              state <= LDC_I2C_RACK;
            end
            else
            begin
              shift <= {shift[6:0], 1'h0};
              sdaOe <= ~shift[6];
              bitCnt <= bitCnt + 4'h1;
            end
          default:
            state <= LDC_I2C_IDLE;
        endcase
      end
    end
  end
endmodule

// *** ldc_checker_asserts.sv ***
// port checks for the LED dimming channel control block
`timescale 1ns/100ps
module ldc_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // straps and pins
  input wire logic [2:0] string_config_strap,
  input wire logic [2:0] modeStrap,
  input wire logic [2:0] dim_frequency_strap,
  input wire logic pwmIn,
  input wire logic sclIn,
  // outputs
  input wire logic sdaOe,
  input wire logic [5:0] sinkEnable,
  input wire logic [71:0] sinkLevel
);
  // ***
  // strap copy
  // ***
  logic taken;
  logic live;
  logic [8:0] strap;
  // own copy, so later strap wiggles must not matter
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      taken <= 1'b0;
      live <= 1'b0;
      strap <= 9'h000;
    end
    else if (ce)
    begin
      taken <= 1'b1;
      live <= taken;
      if (!taken)
        strap <= {dim_frequency_strap, modeStrap, string_config_strap};
    end
  end
  wire [2:0] cfg = strap[2:0];
  wire [1:0] mode = strap[4:3];
  wire [5:0] mask = (cfg == 3'h1) ? 6'h1F : (cfg == 3'h2) ? 6'h0F :
    (cfg == 3'h3) ? 6'h07 : (cfg == 3'h4) ? 6'h03 : 6'h3F;
  wire [71:0] lvlMask = {{12{mask[5]}}, {12{mask[4]}}, {12{mask[3]}},
    {12{mask[2]}}, {12{mask[1]}}, {12{mask[0]}}};
  wire pairOk = sinkEnable[1] == sinkEnable[0] && sinkEnable[3] == sinkEnable[2] &&
    sinkEnable[5] == sinkEnable[4];
  wire trioOk = sinkEnable[2:0] == {3{sinkEnable[0]}} && sinkEnable[5:3] == {3{sinkEnable[3]}};
  wire groupOk = (cfg == 3'h5) ? pairOk : (cfg == 3'h6) ? trioOk :
    (cfg != 3'h7 || sinkEnable == {6{sinkEnable[0]}});
  wire sixPs = live && cfg == 3'h0 && mode == 2'h0 && strap[8:6] == 3'h7;
  // ***
  // checks
  // ***
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  chk_quiet_until_live: assert property (!live |-> sinkEnable == 6'h00)
    else $error("sink gate on before straps taken");
  chk_inactive_dark: assert property (live |-> (sinkEnable & ~mask) == 6'h00)
    else $error("unused sink conducting");
  chk_inactive_level: assert property (live |-> (sinkLevel & ~lvlMask) == 72'h0)
    else $error("unused sink has a level");
  chk_gang_together: assert property (live |-> groupOk)
    else $error("ganged sinks split");
  chk_direct_follow: assert property (live && $past(live) && mode == 2'h3 |->
    sinkEnable == ($past(pwmIn) ? mask : 6'h00))
    else $error("direct mode gate not following pin");
  chk_ack_in_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data pulled while clock high");
  chk_sda_steady_high: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("data moved while clock high");
  chk_sink1_lag: assert property (sixPs && $rose(sinkEnable[0]) && !sinkEnable[1] |->
    ##[415:435] $rose(sinkEnable[1]))
    else $error("second sink lag wrong");
endmodule
bind led_dimming_channel_control ldc_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .ce(ce), .string_config_strap(string_config_strap), .modeStrap(modeStrap),
  .dim_frequency_strap(dim_frequency_strap), .pwmIn(pwmIn), .sclIn(sclIn),
  .sdaOe(sdaOe), .sinkEnable(sinkEnable), .sinkLevel(sinkLevel));

// *** ldc_led_strings.sv ***
// model of the LED strings: stamps gate edges of each sink
`timescale 1ns/100ps
module ldc_led_strings (
  // clock
  input wire logic sys_clk,
  // sinks and board wiring
  input wire logic [5:0] sinkEnable,
  input wire logic [5:0] boardMask
);
  int cyc = 0;
  int rise [6] = '{default: 0};
  int prevRise [6] = '{default: 0};
  int fall [6] = '{default: 0};
  logic [5:0] last = 6'h00;
  logic litUnused = 1'b0;
  always @(posedge sys_clk)
  begin
    cyc++;
    for (int i = 0; i < 6; i++)
    begin
      if (sinkEnable[i] && !last[i])
      begin
        prevRise[i] = rise[i];
        rise[i] = cyc;
      end
      if (!sinkEnable[i] && last[i])
        fall[i] = cyc;
    end
    // grounded sinks carry no string, so conduction there is a fault
    if ((sinkEnable & ~boardMask) != 6'h00)
      litUnused = 1'b1;
    last = sinkEnable;
  end
endmodule

// *** led_dimming_channel_control_bench.sv ***
// self-checking bench of the LED dimming channel control block
`timescale 1ns/100ps
`include "ldc_cfg.svh"
module led_dimming_channel_control_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclM = 1'b1;
  logic sdaM = 1'b1;
  logic pwmIn = 1'b0;
  logic [2:0] cfgS = 3'h0;
  logic [2:0] modeS = 3'h0;
  logic [2:0] freqS = 3'h7;
  logic [5:0] board = 6'h3F;
  logic [6:0] dev = `LDC_ADDR_LOW;
  wire sdaOe;
  wire sdaOut;
  wire [5:0] sinkEnable;
  wire [71:0] sinkLevel;
  // pull-up on the data line, the block only pulls low
  wire sdaLine = sdaM & (sdaOe ? sdaOut : 1'b1);
  int err_total = 0;
  int checks_done = 0;
  always #10 sys_clk = ~sys_clk;
  led_dimming_channel_control u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1),
    .string_config_strap(cfgS), .modeStrap(modeS), .dim_frequency_strap(freqS),
    .pwmIn(pwmIn), .sclIn(sclM), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sinkEnable(sinkEnable), .sinkLevel(sinkLevel));
  ldc_led_strings u_leds (.sys_clk(sys_clk), .sinkEnable(sinkEnable), .boardMask(board));
  // ***
  // helpers
  // ***
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic near(input string what, input int exp, input int got);
    checks_done++;
    if (got < exp - 3 || got > exp + 3)
    begin
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
      err_total++;
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d, checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic reset_to(input logic [2:0] cfg, input logic [2:0] mode, input logic [5:0] m);
    rst_b <= 1'b0;
    cfgS <= cfg;
    modeS <= mode;
    board <= m;
    tk(6);
    rst_b <= 1'b1;
    tk(4);
  endtask
  // five clocks per phase keeps well above the three-clock minimum
  task automatic bitx(input logic b, output logic r);
    sdaM <= b;
    tk(5);
    sclM <= 1'b1;
    tk(5);
    r = sdaLine;
    sclM <= 1'b0;
    tk(5);
  endtask
  task automatic byt(input logic [7:0] d, input logic ma, output logic [7:0] r,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(ma, ack);
  endtask
  task automatic start;
    sdaM <= 1'b1;
    tk(3);
    sclM <= 1'b1;
    tk(5);
    sdaM <= 1'b0;
    tk(5);
    sclM <= 1'b0;
    tk(5);
  endtask
  task automatic stop;
    sdaM <= 1'b0;
    tk(3);
    sclM <= 1'b1;
    tk(5);
    sdaM <= 1'b1;
    tk(5);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
    output logic ok);
    logic [7:0] r;
    logic k0;
    logic k1;
    logic k2;
    start;
    byt({a, 1'b0}, 1'b1, r, k0);
    byt(p, 1'b1, r, k1);
    byt(d, 1'b1, r, k2);
    stop;
    ok = !(k0 | k1 | k2);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic k;
    start;
    byt({dev, 1'b0}, 1'b1, d, k);
    byt(p, 1'b1, d, k);
    start;
    byt({dev, 1'b1}, 1'b1, d, k);
    byt(8'hFF, 1'b1, d, k);
    stop;
  endtask
  // ***
  // scenarios
  // ***
  task automatic defaults_check;
    logic [7:0] p [7] = '{`LDC_REG_SRC, `LDC_REG_SLOPE, `LDC_REG_DITHER,
      `LDC_REG_STATUS, 8'h10, 8'h11, 8'h20};
    logic [7:0] x [7] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hFF, 8'h0F, 8'h00};
    logic [7:0] d;
    logic ok;
    reset_to(3'h0, 3'h0, 6'h3F);
    wr(dev, `LDC_REG_STATUS, 8'h00, ok);
    check("write ack", 16'h0001, {15'h0, ok});
    for (int i = 0; i < 7; i++)
    begin
      rd(p[i], d);
      check("register", {8'h0, x[i]}, {8'h0, d});
    end
    for (int i = 0; i < 6; i++)
      check("reset level", 16'h0FFF, {4'h0, sinkLevel[12*i +: 12]});
  endtask
  task automatic code_scale;
    logic ok;
    wr(dev, 8'h10, 8'h00, ok);
    wr(dev, 8'h11, 8'h08, ok);
    wr(dev, 8'h14, 8'h00, ok);
    wr(dev, 8'h15, 8'h00, ok);
    tk(4);
    check("scaled level", 16'h0800, {4'h0, sinkLevel[11:0]});
    check("other level", 16'h0FFF, {4'h0, sinkLevel[23:12]});
    check("zero code level", 16'h0000, {4'h0, sinkLevel[35:24]});
  endtask
  task automatic phase_run(input logic [2:0] cfg, input logic [5:0] m, input int k,
    input int lag);
    int per;
    int hi;
    int d;
    logic ok;
    reset_to(cfg, 3'h0, m);
    wr(dev, `LDC_REG_SRC, 8'h01, ok);
    wr(dev, `LDC_REG_SLOPE, 8'h00, ok);
    wr(dev, `LDC_REG_DBRT_L, 8'h00, ok);
    wr(dev, `LDC_REG_DBRT_H, 8'h80, ok);
    cfgS <= ~cfg;
    tk(9000);
    per = u_leds.rise[0] - u_leds.prevRise[0];
    hi = u_leds.fall[0] - u_leds.rise[0];
    d = u_leds.rise[k] - u_leds.rise[0];
    if (hi < 0)
      hi += per;
    if (d < 0)
      d += per;
    near("period", 2560, per);
    near("high time", 1280, hi);
    near("group lag", lag, d);
    check("unused sink lit", 16'h0, {15'h0, u_leds.litUnused});
  endtask
  task automatic mode_walk;
    logic [7:0] d;
    logic ok;
    for (int m = 0; m < 4; m++)
    begin
      reset_to(3'h4, {1'b1, m[1:0]}, 6'h03);
      dev = `LDC_ADDR_HIGH;
      wr(`LDC_ADDR_LOW, `LDC_REG_SRC, 8'h01, ok);
      check("other address", 16'h0, {15'h0, ok});
      rd(`LDC_REG_STATUS, d);
      check("mode status", {8'h0, 3'h5, m[1:0], 3'h4}, {8'h0, d});
      // pin at zero: hybrid holds the knee current, current mode goes dark but gated on
      if (m == 1)
        check("hybrid level", 16'h01FF, {4'h0, sinkLevel[11:0]});
      if (m == 2)
        check("current level", 16'h0000, {4'h0, sinkLevel[11:0]});
      if (m == 2)
        check("current gate", 16'h0003, {10'h0, sinkEnable});
      if (m == 3)
      begin
        pwmIn <= 1'b1;
        tk(4);
        check("direct gate on", 16'h0003, {10'h0, sinkEnable});
        pwmIn <= 1'b0;
        tk(4);
        check("direct gate off", 16'h0000, {10'h0, sinkEnable});
      end
    end
    dev = `LDC_ADDR_LOW;
  endtask
  initial
  begin
    defaults_check;
    code_scale;
    phase_run(3'h0, 6'h3F, 1, 425);
    phase_run(3'h1, 6'h1F, 1, 510);
    phase_run(3'h6, 6'h3F, 3, 1280);
    mode_walk;
    complete_run;
  end
  initial
  begin
    tk(80000);
    err_total++;
    complete_run;
  end
endmodule
